// ### rtl/stream_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = vfb_pkg::FIFO_WORDS
) (
	input  wire logic                       mclk,     // Core clock
	input  wire logic                       rst,      // Sync reset
	input  wire logic                       flush,    // Drop all words
	input  wire logic [WIDTH-1:0]           inData,   // Word to store
	input  wire logic                       inValid,  // Store request
	output logic                            inReady,  // Room for a word
	output logic [WIDTH-1:0]                outData,  // Head word
	output logic                            outValid, // Head word present
	input  wire logic                       outReady, // Head word taken
	output logic [$clog2(DEPTH+1)-1:0]      level     // Words held
);
	import vfb_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);
	localparam int LVL_W = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] rdPtr_q;
	logic [LVL_W-1:0] count_q;
	logic             push;
	logic             load;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("stream_fifo: DEPTH must be a power of two");
	end

	// Handshake and fill level
	assign inReady = count_q < LVL_W'(DEPTH);
	assign push    = inValid && inReady;
	assign load    = count_q != '0 && (!outValid || outReady);
	assign level   = count_q + LVL_W'(outValid);

	// Storage array
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wrPtr_q] <= inData;
		end
	end

	// Pointers and count
	always_ff @(posedge mclk) begin
		if (rst || flush) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + PTR_W'(1);
			end
			if (load) begin
				rdPtr_q <= rdPtr_q + PTR_W'(1);
			end
			count_q <= count_q + LVL_W'(push) - LVL_W'(load);
		end
	end

	// Registered head word
	always_ff @(posedge mclk) begin
		if (rst || flush) begin
			outValid <= 1'b0;
		end else if (load) begin
			outValid <= 1'b1;
			outData  <= mem_q[rdPtr_q];
		end else if (outReady) begin
			outValid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### rtl/vfb_pkg.sv
package vfb_pkg;
	// Frame dimension limits and defaults
	localparam int DIM_MIN    = 64;
	localparam int DIM_MAX    = 4096;
	localparam int DEF_WIDTH  = 720;
	localparam int DEF_HEIGHT = 480;
	localparam int DIM_W      = 13;
	localparam int CNT_W      = 26;
	localparam logic [DIM_W-1:0] RST_WIDTH  = DIM_W'(DEF_WIDTH);
	localparam logic [DIM_W-1:0] RST_HEIGHT = DIM_W'(DEF_HEIGHT);

	// Parameter register byte offsets
	localparam logic [4:0] OFS_WIDTH  = 5'h00;
	localparam logic [4:0] OFS_HEIGHT = 5'h04;
	localparam logic [4:0] OFS_APPLY  = 5'h08;
	localparam logic       RST_APPLY  = 1'h0;

	// Buffering, bursts, storage
	localparam int FIFO_WORDS  = 16;
	localparam int BURST_WORDS = 8;
	localparam int FRAME_SLOTS = 3;
	localparam int PIXEL_BITS  = 16;
	localparam int PBUS_BITS   = 32;
	localparam int OUT_DIV     = 2;
	localparam logic [31:0] MEM_BASE = 32'h0000_0000;

	typedef enum {FMT_MONO, FMT_YC422, FMT_YC444} format_t;
	typedef enum {MS_IDLE, MS_WR_CMD, MS_WR_DATA, MS_RD_CMD, MS_RD_DATA}
		mem_state_t;

	// Stored words per frame for a format and packing
	function automatic logic [CNT_W-1:0] frame_words(
		input logic [DIM_W-1:0] w,
		input logic [DIM_W-1:0] h,
		input format_t          fmt,
		input logic             par
	);
		logic [CNT_W-1:0] px;
		px = CNT_W'(w) * CNT_W'(h);
		if (par || fmt == FMT_MONO) begin
			return px;
		end
		if (fmt == FMT_YC422) begin
			return px << 1;
		end
		return px + (px << 1);
	endfunction
endpackage

// ### rtl/video_frame_buffer_control.sv
// Behaviour
// R1: Parameter bus runs on the core clock; no separate clock in this build.
// R2: Host gives valid data and address with each write strobe.
// R3: Apply copies all staged registers; unwritten ones keep old values.
// R4: Read data shows the register addressed one cycle earlier.
// R5: Host keeps low address bits zero for 32 or 16 bit buses.
// R6: 4:4:4 planes interleaved serially or packed in parallel; words kept.
// R7: Serial 4:2:2 order Cb, Y, Cr, Y kept in and out.
// R8: Parallel 4:2:2 luma high half, Cb then Cr low half.
// R9: Output pixels pause while the output gate is low.
// R10: Without conversion, output starts after one full input frame.
// R11: Without conversion, a new input frame abandons the output frame.
// R12: Without conversion, output stops after the last input frame.
// R13: With conversion, oldest stored frame exported; advance on newer frame.
// R14: With conversion and no new input, last frame repeats forever.
// R15: Memory full of unconsumed frames: latest input frame is overwritten.
// R16: Write FIFO half full starts write bursts until it is empty.
// R17: Read burst when read FIFO below half and no write pending.
// R18: Traffic in bursts; write/read switch only at burst ends.
// R19: Parameter writes ignored while the apply flag is set.
// R20: Apply flag loads parameters at next frame start, then clears.
// R21: Host keeps frame sizes even and within 64 to 4096.
// R22: With conversion the output stream runs on its own pixel rate.
// R23: Source marks the first active pixel of each frame.
// R24: Drop and repeat flags mark discarded or replayed frames.
// R25: Reset clears the apply flag and loads the default frame size.
`timescale 1ns/100ps
`default_nettype none
module video_frame_buffer_control #(
	parameter vfb_pkg::format_t FORMAT = vfb_pkg::FMT_YC422,
	parameter bit               PARALLEL   = 1'b1,
	parameter bit               RATE_CONV  = 1'b1,
	parameter int               PIX_W      = vfb_pkg::PIXEL_BITS,
	parameter int               PBUS_W     = vfb_pkg::PBUS_BITS,
	parameter int               MAX_WIDTH  = vfb_pkg::DEF_WIDTH,
	parameter int               MAX_HEIGHT = vfb_pkg::DEF_HEIGHT,
	parameter int               FIFO_DEPTH = vfb_pkg::FIFO_WORDS,
	parameter int               BURST_LEN  = vfb_pkg::BURST_WORDS,
	parameter int               SLOTS      = vfb_pkg::FRAME_SLOTS,
	parameter int               DIV        = vfb_pkg::OUT_DIV,
	parameter logic [31:0]      BASE       = vfb_pkg::MEM_BASE
) (
	input  wire logic              mclk,             // Core clock
	input  wire logic              rst,              // Sync reset
	input  wire logic [PIX_W-1:0]  pixelIn,          // Input pixel word
	input  wire logic              pixelValidIn,     // Input word valid
	input  wire logic              frameStartIn,     // First pixel of frame
	output logic                   pixelReady,       // Input word accepted
	output logic [PIX_W-1:0]       pixelOut,         // Output pixel word
	output logic                   pixelValidOut,    // Output word valid
	output logic                   frameStartOut,    // First output pixel
	input  wire logic              outputGate,       // Output allowed
	input  wire logic              cmdReady,         // Memory takes command
	output logic [31:0]            memAddr,          // Memory byte address
	output logic                   writeCmd,         // Memory write command
	output logic                   readCmd,          // Memory read command
	output logic [PIX_W-1:0]       writeData,        // Memory write word
	output logic                   writeDataValid,   // Write word valid
	input  wire logic              writeDataReady,   // Memory wants data
	input  wire logic [PIX_W-1:0]  readData,         // Memory read word
	input  wire logic              readDataValid,    // Read word valid
	input  wire logic              paramWriteStrobe, // Parameter write
	input  wire logic [4:0]        paramAddress,     // Parameter address
	input  wire logic [PBUS_W-1:0] paramWriteData,   // Parameter data
	output logic [PBUS_W-1:0]      paramReadData,    // Parameter readback
	output logic                   frameDropped,     // Frame discarded
	output logic                   frameRepeated,    // Frame replayed
	output logic                   frameResync       // Input frame cut short
);
	import vfb_pkg::*;

	localparam int LVL_W  = $clog2(FIFO_DEPTH + 1);
	localparam int SLOT_W = $clog2(SLOTS);
	localparam int BC_W   = $clog2(BURST_LEN);
	localparam int BYTES  = (PIX_W + 7) / 8;
	localparam logic [LVL_W-1:0] HALF    = LVL_W'(FIFO_DEPTH / 2);
	localparam logic [LVL_W-1:0] RDY_LVL = LVL_W'(FIFO_DEPTH - 2);
	localparam logic [CNT_W-1:0] MAX_WORDS = frame_words(
		DIM_W'(MAX_WIDTH), DIM_W'(MAX_HEIGHT), FORMAT, PARALLEL);

	if (FIFO_DEPTH < 2 * BURST_LEN || BURST_LEN < 2 ||
		(BURST_LEN & (BURST_LEN - 1)) != 0) begin : g_chk_burst
		$error("burst must be a power of two and fit half the FIFO");
	end
	if (PBUS_W != 16 && PBUS_W != 32) begin : g_chk_bus
		$error("parameter bus must be 16 or 32 bits");
	end
	if (SLOTS < 3 || DIV < 1 || PIX_W < 8) begin : g_chk_misc
		$error("need three frame slots, a divider and 8-bit pixels");
	end
	if (MAX_WIDTH < DIM_MIN || MAX_WIDTH > DIM_MAX || MAX_WIDTH % 2 != 0 ||
		MAX_HEIGHT < DIM_MIN || MAX_HEIGHT > DIM_MAX ||
		MAX_HEIGHT % 2 != 0) begin : g_chk_dim
		$error("frame size must be even and within limits");
	end

	// Byte address of a word within a frame slot
	function automatic logic [31:0] word_addr(
		input logic [SLOT_W-1:0] s,
		input logic [CNT_W-1:0]  i
	);
		return BASE + (32'(s) * 32'(MAX_WORDS) + 32'(i)) * 32'(BYTES);
	endfunction

	// Ring successor of a slot
	function automatic logic [SLOT_W-1:0] next_slot(
		input logic [SLOT_W-1:0] s
	);
		return (s == SLOT_W'(SLOTS - 1)) ? '0 : s + SLOT_W'(1);
	endfunction

	logic [DIM_W-1:0]  stageW_q, stageH_q, workW_q, workH_q;
	logic              applyFlag_q;
	logic              inFrame_q, inEnd_q;
	logic [CNT_W-1:0]  inCnt_q, inWords;
	logic              inPush, inSof;
	logic [PIX_W:0]    wrOutData, rdOutData;
	logic              wrOutValid, rdOutValid, rdOutReady;
	logic              rdInReady;
	logic [LVL_W-1:0]  wrLevel, rdLevel;
	mem_state_t        state_q;
	logic [BC_W-1:0]   burstCnt_q;
	logic [SLOT_W-1:0] wrSlot_q, rdSlot_q, latest_q, wrSlotUse;
	logic [CNT_W-1:0]  wrIdx_q, wrFrameWords_q, doneWords_q, wrIdxUse;
	logic [CNT_W-1:0]  rdIdx_q, rdWordIdx_q, rdFrameWords_q;
	logic              wrStarted_q, wrDrain_q, rdActive_q, restartReq_q;
	logic [SLOT_W:0]   stored_q;
	logic              wrHeadSof, wrPop, frameDone, startWr, newSlot;
	logic              full, overwrite, rdFetched, rdEnd, rdAdvance;
	logic              restart, rdFlush, startRd, rdPush;
	logic [$clog2(DIV+1)-1:0] divCnt_q;
	logic              pixEn_q, outStep;

	// Staged and working parameter registers
	// R1 bus on mclk
	always_ff @(posedge mclk) begin
		if (rst) begin
			// R25 reset defaults
			stageW_q    <= RST_WIDTH;
			stageH_q    <= RST_HEIGHT;
			workW_q     <= RST_WIDTH;
			workH_q     <= RST_HEIGHT;
			applyFlag_q <= RST_APPLY;
		end else begin
			// R19 writes only while idle
			if (paramWriteStrobe && !applyFlag_q) begin
				case (paramAddress)
					OFS_WIDTH:  stageW_q    <= paramWriteData[DIM_W-1:0];
					OFS_HEIGHT: stageH_q    <= paramWriteData[DIM_W-1:0];
					OFS_APPLY:  applyFlag_q <= paramWriteData[0];
					default: ;
				endcase
			end
			// R20 load at frame start
			if (applyFlag_q && inSof) begin
				// R3 copy all staged
				workW_q     <= stageW_q;
				workH_q     <= stageH_q;
				applyFlag_q <= 1'b0;
			end
		end
	end

	// R4 one-cycle read latency
	always_ff @(posedge mclk) begin
		if (rst) begin
			paramReadData <= '0;
		end else begin
			case (paramAddress)
				OFS_WIDTH:  paramReadData <= PBUS_W'(stageW_q);
				OFS_HEIGHT: paramReadData <= PBUS_W'(stageH_q);
				OFS_APPLY:  paramReadData <= PBUS_W'(applyFlag_q);
				default:    paramReadData <= '0;
			endcase
		end
	end

	// Input acceptance; words pass through unchanged
	assign inWords = frame_words(workW_q, workH_q, FORMAT, PARALLEL);
	assign inSof   = pixelValidIn && pixelReady && frameStartIn;
	assign inPush  = pixelValidIn && pixelReady && (frameStartIn || inFrame_q);

	// Input frame tracking and back-pressure
	always_ff @(posedge mclk) begin
		if (rst) begin
			inFrame_q   <= 1'b0;
			inEnd_q     <= 1'b0;
			inCnt_q     <= '0;
			frameResync <= 1'b0;
			pixelReady  <= 1'b0;
		end else begin
			pixelReady  <= wrLevel <= RDY_LVL;
			inEnd_q     <= 1'b0;
			frameResync <= inSof && inFrame_q;
			if (inPush) begin
				inCnt_q <= frameStartIn ? CNT_W'(1) : inCnt_q + CNT_W'(1);
				inFrame_q <= 1'b1;
				if (!frameStartIn && inCnt_q + CNT_W'(1) == inWords) begin
					inFrame_q <= 1'b0;
					inEnd_q   <= 1'b1;
				end
			end
		end
	end

	// R6 R7 R8 plane order kept word for word
	stream_fifo #(
		.WIDTH (PIX_W + 1),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.mclk     (mclk),
		.rst      (rst),
		.flush    (1'b0),
		.inData   ({frameStartIn, pixelIn}),
		.inValid  (inPush),
		.inReady  (),
		.outData  (wrOutData),
		.outValid (wrOutValid),
		.outReady (wrPop),
		.level    (wrLevel)
	);

	stream_fifo #(
		.WIDTH (PIX_W + 1),
		.DEPTH (FIFO_DEPTH)
	) u_rd_fifo (
		.mclk     (mclk),
		.rst      (rst),
		.flush    (rdFlush),
		.inData   ({rdWordIdx_q == '0, readData}),
		.inValid  (rdPush),
		.inReady  (rdInReady),
		.outData  (rdOutData),
		.outValid (rdOutValid),
		.outReady (rdOutReady),
		.level    (rdLevel)
	);

	// Scheduling decisions
	assign wrHeadSof = wrOutValid && wrOutData[PIX_W];
	assign wrPop     = state_q == MS_WR_DATA && writeDataReady &&
		wrOutValid && !(wrHeadSof && burstCnt_q != '0);
	assign frameDone = wrPop && wrIdx_q + CNT_W'(1) == wrFrameWords_q;
	// R16 half full starts, drain to empty
	assign startWr   = state_q == MS_IDLE && wrOutValid &&
		(wrLevel >= HALF || wrDrain_q);
	assign newSlot   = startWr && wrHeadSof;
	assign full      = RATE_CONV && stored_q != '0 &&
		next_slot(wrSlot_q) == rdSlot_q;
	// R15 overwrite latest when full
	assign overwrite = newSlot && wrStarted_q && full;
	assign wrSlotUse = (newSlot && wrStarted_q && !full) ?
		next_slot(wrSlot_q) : wrSlot_q;
	assign wrIdxUse  = newSlot ? '0 : wrIdx_q;
	assign rdFetched = rdActive_q && rdIdx_q >= rdFrameWords_q;
	assign restart   = state_q == MS_IDLE && !startWr && restartReq_q;
	assign rdEnd     = state_q == MS_IDLE && !startWr && !restart &&
		rdFetched;
	// R13 advance to next oldest
	assign rdAdvance = RATE_CONV && rdEnd && stored_q > (SLOT_W+1)'(1);
	assign rdFlush   = restart;
	// R17 read only below half, no write
	assign startRd   = state_q == MS_IDLE && !startWr && !restartReq_q &&
		rdActive_q && !rdFetched && rdLevel < HALF;
	assign rdPush    = state_q == MS_RD_DATA && readDataValid &&
		rdWordIdx_q < rdFrameWords_q && rdInReady;

	// Memory burst engine and frame slot control
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q        <= MS_IDLE;
			burstCnt_q     <= '0;
			memAddr        <= '0;
			writeCmd       <= 1'b0;
			readCmd        <= 1'b0;
			writeData      <= '0;
			writeDataValid <= 1'b0;
			wrSlot_q       <= '0;
			wrIdx_q        <= '0;
			wrFrameWords_q <= MAX_WORDS;
			wrStarted_q    <= 1'b0;
			wrDrain_q      <= 1'b0;
			latest_q       <= '0;
			doneWords_q    <= MAX_WORDS;
			rdSlot_q       <= '0;
			rdIdx_q        <= '0;
			rdWordIdx_q    <= '0;
			rdFrameWords_q <= MAX_WORDS;
			rdActive_q     <= 1'b0;
			restartReq_q   <= 1'b0;
			frameDropped   <= 1'b0;
			frameRepeated  <= 1'b0;
		end else begin
			writeDataValid <= 1'b0;
			// R24 drop and repeat flags
			frameDropped   <= overwrite;
			frameRepeated  <= 1'b0;
			if (inEnd_q) begin
				wrDrain_q <= 1'b1;
			end
			if (!wrOutValid && !inPush) begin
				wrDrain_q <= 1'b0;
			end
			// R18 choose work only at burst ends
			case (state_q)
				MS_IDLE: begin
					if (startWr) begin
						wrDrain_q <= 1'b1;
						memAddr   <= word_addr(wrSlotUse, wrIdxUse);
						writeCmd  <= 1'b1;
						state_q   <= MS_WR_CMD;
						if (newSlot) begin
							wrSlot_q       <= wrSlotUse;
							wrIdx_q        <= '0;
							wrStarted_q    <= 1'b1;
							wrFrameWords_q <= inWords;
						end
					end else if (restart) begin
						// R11 abandon and restart
						restartReq_q   <= 1'b0;
						frameDropped   <= rdActive_q || rdLevel != '0;
						rdSlot_q       <= latest_q;
						rdIdx_q        <= '0;
						rdWordIdx_q    <= '0;
						rdFrameWords_q <= doneWords_q;
						rdActive_q     <= 1'b1;
					end else if (rdEnd) begin
						rdIdx_q        <= '0;
						rdWordIdx_q    <= '0;
						rdFrameWords_q <= doneWords_q;
						if (!RATE_CONV) begin
							// R12 stop after last frame
							rdActive_q <= 1'b0;
						end else if (rdAdvance) begin
							rdSlot_q <= next_slot(rdSlot_q);
						end else begin
							// R14 replay last frame
							frameRepeated <= 1'b1;
						end
					end else if (RATE_CONV && !rdActive_q &&
						stored_q != '0) begin
						// R13 start after a full frame
						rdActive_q     <= 1'b1;
						rdFrameWords_q <= doneWords_q;
					end else if (startRd) begin
						memAddr <= word_addr(rdSlot_q, rdIdx_q);
						readCmd <= 1'b1;
						state_q <= MS_RD_CMD;
					end
				end
				MS_WR_CMD: begin
					if (cmdReady) begin
						writeCmd   <= 1'b0;
						burstCnt_q <= '0;
						state_q    <= MS_WR_DATA;
					end
				end
				MS_WR_DATA: begin
					if (wrPop) begin
						writeData      <= wrOutData[PIX_W-1:0];
						writeDataValid <= 1'b1;
						wrIdx_q        <= wrIdx_q + CNT_W'(1);
						burstCnt_q     <= burstCnt_q + BC_W'(1);
						if (burstCnt_q == BC_W'(BURST_LEN - 1)) begin
							state_q <= MS_IDLE;
						end
					end else if (!wrOutValid ||
						(wrHeadSof && burstCnt_q != '0)) begin
						state_q <= MS_IDLE;
					end
				end
				MS_RD_CMD: begin
					if (cmdReady) begin
						readCmd    <= 1'b0;
						burstCnt_q <= '0;
						rdIdx_q    <= rdIdx_q + CNT_W'(BURST_LEN);
						state_q    <= MS_RD_DATA;
					end
				end
				MS_RD_DATA: begin
					if (readDataValid) begin
						rdWordIdx_q <= rdWordIdx_q + CNT_W'(1);
						burstCnt_q  <= burstCnt_q + BC_W'(1);
						if (burstCnt_q == BC_W'(BURST_LEN - 1)) begin
							state_q <= MS_IDLE;
						end
					end
				end
				default: state_q <= MS_IDLE;
			endcase
			if (frameDone) begin
				latest_q    <= wrSlot_q;
				doneWords_q <= wrFrameWords_q;
				if (!RATE_CONV) begin
					restartReq_q <= 1'b1;
				end
			end
		end
	end

	// Count of complete unconsumed frames
	always_ff @(posedge mclk) begin
		if (rst) begin
			stored_q <= '0;
		end else if (RATE_CONV && frameDone) begin
			stored_q <= stored_q + (SLOT_W+1)'(1);
		end else if (rdAdvance || overwrite) begin
			stored_q <= stored_q - (SLOT_W+1)'(1);
		end
	end

	// R22 output pixel rate divider
	always_ff @(posedge mclk) begin
		if (rst) begin
			divCnt_q <= '0;
			pixEn_q  <= 1'b0;
		end else if (divCnt_q == ($clog2(DIV+1))'(DIV - 1)) begin
			divCnt_q <= '0;
			pixEn_q  <= 1'b1;
		end else begin
			divCnt_q <= divCnt_q + ($clog2(DIV+1))'(1);
			pixEn_q  <= 1'b0;
		end
	end

	// R9 gate pauses output
	assign outStep    = outputGate && (RATE_CONV ? pixEn_q : 1'b1);
	assign rdOutReady = outStep;

	// Output pixel stream
	always_ff @(posedge mclk) begin
		if (rst) begin
			pixelOut      <= '0;
			pixelValidOut <= 1'b0;
			frameStartOut <= 1'b0;
		end else begin
			pixelValidOut <= outStep && rdOutValid;
			frameStartOut <= outStep && rdOutValid && rdOutData[PIX_W];
			if (outStep && rdOutValid) begin
				pixelOut <= rdOutData[PIX_W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	input  wire logic        mclk,           // Clock
	input  wire logic        rst,            // Reset
	input  wire logic        stall,          // Hold commands
	input  wire logic [31:0] memAddr,        // Address
	input  wire logic        writeCmd,       // Write command
	input  wire logic        readCmd,        // Read command
	input  wire logic [15:0] writeData,      // Write word
	input  wire logic        writeDataValid, // Write word valid
	output logic             cmdReady,       // Command taken
	output logic             writeDataReady, // Word wanted
	output logic [15:0]      readData,       // Read word
	output logic             readDataValid   // Read word valid
);
	logic [15:0] mem [int];
	logic [31:0] wA, rA;
	int          wrLeft, rdLeft;
	// Quiet outputs before the first edge
	initial begin
		cmdReady = 1'b0;
		writeDataReady = 1'b0;
		readDataValid = 1'b0;
		readData = 16'h0f0f;
	end
	always @(posedge mclk) begin
		cmdReady <= 1'b0;
		writeDataReady <= 1'b0;
		readDataValid <= 1'b0;
		readData <= ~readData;
		if (rst) begin
			wrLeft = 0;
			rdLeft = 0;
		end else begin
			if (writeDataValid) begin
				mem[wA] = writeData;
				wA = wA + 2;
			end
			if (cmdReady && writeCmd) begin
				wrLeft = 8;
				wA = memAddr;
			end
			if (cmdReady && readCmd) begin
				rdLeft = 8;
				rA = memAddr;
			end
			if (wrLeft > 0) begin
				writeDataReady <= 1'b1;
				wrLeft--;
			end else if (rdLeft > 0) begin
				readData <= mem.exists(rA) ? mem[rA] : 16'h5a5a;
				readDataValid <= 1'b1;
				rA = rA + 2;
				rdLeft--;
			end else if ((writeCmd || readCmd) && !cmdReady && !stall) begin
				cmdReady <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/video_frame_buffer_control_sva.sv
`timescale 1ns/100ps
`default_nettype none
module video_frame_buffer_control_sva #(
	parameter int BURST_LEN = 8
) (
	input wire logic        mclk,           // Clock
	input wire logic        rst,            // Reset
	input wire logic        outputGate,     // Gate
	input wire logic        pixelValidOut,  // Word out
	input wire logic        frameStartOut,  // Frame out
	input wire logic        cmdReady,       // Cmd taken
	input wire logic        writeCmd,       // Write
	input wire logic        readCmd,        // Read
	input wire logic [31:0] memAddr,        // Address
	input wire logic        writeDataValid, // Word
	input wire logic        writeDataReady, // Pop
	input wire logic        pixelReady,     // Ready
	input wire logic        frameResync     // Resync
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	int wdCnt;
	// Words since last write command
	always_ff @(posedge mclk) begin
		if (rst || (writeCmd && cmdReady)) begin
			wdCnt <= 0;
		end else if (writeDataValid) begin
			wdCnt <= wdCnt + 1;
		end
	end
	sequence s_wr_wait; writeCmd && !cmdReady; endsequence
	sequence s_rd_wait; readCmd && !cmdReady; endsequence
	sequence s_gate_off; !outputGate [*3]; endsequence
	property p_one_cmd; !(writeCmd && readCmd); endproperty
	a_one_cmd: assert property (p_one_cmd) else $error("two commands");
	property p_wr_hold; s_wr_wait |=> writeCmd && $stable(memAddr); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write dropped");
	property p_rd_hold; s_rd_wait |=> readCmd && $stable(memAddr); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read dropped");
	property p_wd_pop; writeDataValid |-> $past(writeDataReady); endproperty
	a_wd_pop: assert property (p_wd_pop) else $error("unasked word");
	property p_burst; wdCnt <= BURST_LEN; endproperty
	a_burst: assert property (p_burst) else $error("burst too long");
	property p_gate; s_gate_off |-> !pixelValidOut; endproperty
	a_gate: assert property (p_gate) else $error("output while gated");
	property p_rst; $past(rst) |-> !pixelReady && !pixelValidOut
		&& !writeCmd && !readCmd; endproperty
	a_rst: assert property (p_rst) else $error("busy after reset");
	property p_fso; frameStartOut |-> pixelValidOut; endproperty
	a_fso: assert property (p_fso) else $error("start without word");
	property p_resync; frameResync |=> !frameResync; endproperty
	a_resync: assert property (p_resync) else $error("resync not a pulse");
endmodule
bind video_frame_buffer_control video_frame_buffer_control_sva #(
	.BURST_LEN(BURST_LEN)) chk_i (.mclk, .rst, .outputGate, .pixelValidOut,
	.frameStartOut, .cmdReady, .writeCmd, .readCmd, .memAddr, .writeDataValid,
	.writeDataReady, .pixelReady, .frameResync);
`default_nettype wire

// ### sim/video_frame_buffer_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module video_frame_buffer_control_tb;
	import vfb_pkg::*;
	logic        mclk, rst, pixelValidIn, frameStartIn, stall, pixelReady;
	logic        pixelValidOut, frameStartOut, cmdReady, writeCmd, readCmd;
	logic        writeDataValid, writeDataReady, readDataValid;
	logic        paramWriteStrobe, frameDropped, frameRepeated, frameResync;
	logic        outputGate = 1'b0;
	logic [15:0] pixelIn, pixelOut, writeData, readData;
	logic [31:0] memAddr, paramWriteData, paramReadData;
	logic [4:0]  paramAddress;
	int          errCount, nChecks, outWords, frames, resyncs, gcnt, flags;
	video_frame_buffer_control #(.RATE_CONV(1'b0), .MAX_WIDTH(64),
		.MAX_HEIGHT(64)) video_frame_buffer_control_i (.mclk, .rst, .pixelIn,
		.pixelValidIn, .frameStartIn, .pixelReady, .pixelOut, .pixelValidOut,
		.frameStartOut, .outputGate, .cmdReady, .memAddr, .writeCmd, .readCmd,
		.writeData, .writeDataValid, .writeDataReady, .readData, .readDataValid,
		.paramWriteStrobe, .paramAddress, .paramWriteData, .paramReadData,
		.frameDropped, .frameRepeated, .frameResync);
	mem_model mem_model_i (.mclk, .rst, .stall, .memAddr, .writeCmd, .readCmd,
		.writeData, .writeDataValid, .cmdReady, .writeDataReady, .readData,
		.readDataValid);
	// Clock, 4 ns period
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Blanking gaps of three cycles in eight
	always @(posedge mclk) begin
		gcnt++;
		#1 outputGate = (gcnt % 8 >= 3);
	end
	function automatic logic [15:0] pat(input int i);
		return 16'(i * 257) ^ 16'h3c5a;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stopTest;
		$display("checks %0d mismatches %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic timeout;
		errCount++;
		$display("ERROR %0t wait ran out", $time);
		stopTest;
	endtask
	// Output words checked against the source pattern
	always @(posedge mclk) begin
		if (frameResync === 1'b1) resyncs++;
		if ((frameDropped | frameRepeated) === 1'b1) flags++;
		if (pixelValidOut === 1'b1) begin
			if (frameStartOut === 1'b1) begin
				frames++;
				outWords = 0;
			end
			chk(pixelOut, pat(outWords));
			outWords++;
		end
	end
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		paramAddress = a;
		paramWriteData = d;
		paramWriteStrobe = 1'b1;
		@(posedge mclk);
		#1 paramWriteStrobe = 1'b0;
		@(posedge mclk);
		#1;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		paramAddress = a;
		@(posedge mclk);
		#1 chk(paramReadData, exp);
	endtask
	task automatic send(input int n, input int stallAt);
		int i, t, st, low;
		i = 0;
		t = 0;
		st = 0;
		low = 0;
		while (i < n && t < 60000) begin
			pixelValidIn = 1'b1;
			pixelIn = pat(i);
			frameStartIn = (i == 0);
			stall = (i >= stallAt && st < 200);
			if (stall) st++;
			@(posedge mclk);
			if (pixelReady === 1'b1) i++;
			else if (stall) low++;
			#1 t++;
		end
		pixelValidIn = 1'b0;
		frameStartIn = 1'b0;
		stall = 1'b0;
		if (t >= 60000) timeout;
		if (stallAt < n) chk(32'(low > 100), 1);
		@(posedge mclk);
		#1;
	endtask
	task automatic testRegs;
		rd(OFS_WIDTH, 32'(RST_WIDTH));
		rd(OFS_HEIGHT, 32'(RST_HEIGHT));
		rd(OFS_APPLY, 32'h0000_0000);
		rd(5'h0c, 32'h0000_0000);
		wr(OFS_WIDTH, 32'h0000_0040);
		wr(OFS_HEIGHT, 32'h0000_0040);
		wr(OFS_APPLY, 32'h0000_0001);
		rd(OFS_APPLY, 32'h0000_0001);
		wr(OFS_WIDTH, 32'h0000_0064);
		rd(OFS_WIDTH, 32'h0000_0040);
		$display("test regs done");
	endtask
	task automatic testFrame;
		int t;
		send(10, 10);
		rd(OFS_APPLY, 32'h0000_0000);
		rd(OFS_WIDTH, 32'h0000_0040);
		send(4096, 300);
		chk(32'(resyncs > 0), 1);
		chk(frames, 0);
		t = 0;
		while ((frames == 0 || outWords < 4096) && t < 40000) begin
			@(posedge mclk);
			t++;
		end
		if (t >= 40000) timeout;
		chk(frames, 1);
		repeat (3000) @(posedge mclk);
		chk(frames, 1);
		chk(outWords, 4096);
		chk(flags, 0);
		$display("test frame done");
	endtask
	// Reset, then the scenarios
	initial begin
		rst = 1'b1;
		pixelIn = 16'h0000;
		pixelValidIn = 1'b0;
		frameStartIn = 1'b0;
		stall = 1'b0;
		paramWriteStrobe = 1'b0;
		paramAddress = 5'h00;
		paramWriteData = 32'h0000_0000;
		repeat (6) @(posedge mclk);
		#1 rst = 1'b0;
		@(posedge mclk);
		#1 testRegs;
		testFrame;
		stopTest;
	end
endmodule
`default_nettype wire
